// ---- common/addr_mod_pkg.sv ----
// Purpose: shared constants and types for the address modifier arithmetic unit
// Assumes: 24-bit address space, 8 modifier/pointer/offset register sets
// Notes: modifier encodings live here so decode and tests agree
package addr_mod_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int MOD_W = 24;
  localparam int NUM_SETS = 8;
  localparam int SET_W = 3;
  localparam int PIPE_LAT = 1; // cycles from req to result valid

  // ****************************************
  // modifier field layout
  // ****************************************
  localparam int MOD_LOW_W = 16;
  localparam int MWRAP_SEL_BIT = 15;
  localparam int MWRAP_CLR_BIT = 14;
  localparam int MWRAP_FIELD_W = 14;
  localparam logic [15:0] MOD_LINEAR_LOW = 16'hFFFF;
  localparam logic [15:0] MOD_REVERSE_LOW = 16'h0000;
  localparam logic [15:0] MOD_MODULO_MAX = 16'h7FFF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [23:0] PTR_RST = 24'h000000;
  localparam logic [23:0] OFS_RST = 24'h000000;
  localparam logic [23:0] MOD_RST = 24'hFFFFFF;

  // update kind requested by the address generation stage
  typedef enum logic [2:0] {
    UPD_NONE,     // (ptr)
    UPD_POST_INC, // (ptr)+
    UPD_POST_DEC, // (ptr)-
    UPD_POST_ADD, // (ptr)+ofs
    UPD_POST_SUB, // (ptr)-ofs
    UPD_INDEXED,  // (ptr+ofs)
    UPD_PRE_DEC,  // -(ptr)
    UPD_PC_REL    // pc + operand, always linear
  } upd_kind_e;

  // arithmetic type chosen by a modifier
  typedef enum logic [2:0] {
    ARITH_LINEAR,
    ARITH_REVERSE,
    ARITH_MODULO,
    ARITH_MWRAP,
    ARITH_RESERVED
  } arith_e;

endpackage

// ---- rtl/mod_arith_core.sv ----
// Purpose: combinational address arithmetic for every modifier type
// Assumes: inputs stable for the whole cycle; no state
// Notes: one instance serves all register sets; the top selects operands
module mod_arith_core #(
  parameter int AW = 24
) (
  input wire logic [AW-1:0] base_addr,
  input wire logic [AW-1:0] operand,
  input wire logic subtract,
  input wire logic [23:0] modifier,
  input wire logic force_linear,
  output logic [AW-1:0] result,
  output addr_mod_pkg::arith_e arith
);

  // ****************************************
  // helpers
  // ****************************************
  // bit reversal of an address word
  function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] v);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < AW; i++) begin
      r[i] = v[AW-1-i];
    end
    return r;
  endfunction

  // mask of the k low bits, smallest 2^k >= m+1 (m = M-1)
  function automatic logic [AW-1:0] block_mask(input logic [15:0] m);
    logic [AW-1:0] k_mask;
    k_mask = '0;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        k_mask = (AW'(1) << (i + 1)) - AW'(1);
      end
    end
    return k_mask;
  endfunction

  logic [15:0] low16;
  logic [15:0] mod_m1;
  logic [AW-1:0] kmask;
  logic [AW-1:0] modsize;
  logic [AW-1:0] blk_base;
  logic [AW-1:0] blk_ofs;
  logic [AW-1:0] signed_op;
  logic [AW-1:0] mag;
  logic [AW-1:0] lin_sum;
  logic [AW-1:0] rel_sum;
  logic [AW-1:0] rel_wrap;
  logic is_block_mult;

  // ****************************************
  // modifier decode
  // ****************************************
  // upper byte ignored for every type; reserved codes fall back to linear
  always_comb begin
    low16 = modifier[15:0];
    mod_m1 = 16'h0000;
    if (force_linear) begin
      arith = addr_mod_pkg::ARITH_LINEAR;
    end else if (low16 == addr_mod_pkg::MOD_LINEAR_LOW) begin
      arith = addr_mod_pkg::ARITH_LINEAR;
    end else if (low16 == addr_mod_pkg::MOD_REVERSE_LOW) begin
      arith = addr_mod_pkg::ARITH_REVERSE;
    end else if (low16 <= addr_mod_pkg::MOD_MODULO_MAX) begin
      arith = addr_mod_pkg::ARITH_MODULO;
      mod_m1 = low16;
    end else if (low16[addr_mod_pkg::MWRAP_SEL_BIT] && !low16[addr_mod_pkg::MWRAP_CLR_BIT]
                 && ((low16[13:0] & (low16[13:0] + 14'h0001)) == 14'h0000)
                 && (low16[13:0] != 14'h0000)) begin
      arith = addr_mod_pkg::ARITH_MWRAP;
      mod_m1 = {2'b00, low16[13:0]};
    end else begin
      arith = addr_mod_pkg::ARITH_RESERVED;
    end
  end

  // ****************************************
  // arithmetic
  // ****************************************
  // region base from pointer alone: no boundaries are stored anywhere
  always_comb begin
    kmask = block_mask(mod_m1);
    modsize = AW'(mod_m1) + AW'(1);
    blk_base = base_addr & ~kmask;
    blk_ofs = base_addr & kmask;
    signed_op = subtract ? (AW'(0) - operand) : operand;
    mag = operand;
    lin_sum = base_addr + signed_op;
    is_block_mult = ((mag & kmask) == AW'(0)) && (mag != AW'(0));
    rel_sum = '0;
    rel_wrap = '0;
    case (arith)
      addr_mod_pkg::ARITH_REVERSE: begin
        // reverse carry: add in the mirrored domain, mirror back
        rel_sum = bit_rev(base_addr) +
                  (subtract ? (AW'(0) - bit_rev(operand)) : bit_rev(operand));
        result = bit_rev(rel_sum);
      end
      addr_mod_pkg::ARITH_MODULO: begin
        if (is_block_mult) begin
          result = lin_sum;
        end else begin
          // single wrap only; the sign of the step, not add or subtract, picks the way
          rel_sum = blk_ofs + signed_op;
          if (signed_op[AW-1] && rel_sum[AW-1]) begin
            rel_wrap = rel_sum + modsize;
          end else if (!signed_op[AW-1] && (rel_sum >= modsize)) begin
            rel_wrap = rel_sum - modsize;
          end else begin
            rel_wrap = rel_sum;
          end
          result = blk_base | (rel_wrap & kmask);
        end
      end
      addr_mod_pkg::ARITH_MWRAP: begin
        // power of two: masking wraps any number of times
        rel_sum = blk_ofs + signed_op;
        result = blk_base | (rel_sum & kmask);
      end
      default: begin
        result = lin_sum;
      end
    endcase
  end

endmodule

// ---- rtl/address_modifier_arithmetic.sv ----
// Purpose: pointer/offset/modifier register sets with address update arithmetic
// Assumes: decoder issues at most one request per cycle, all inputs synchronous
// Notes: result and write-back appear one cycle after the request
//   loads and updates share one write path per set; loads take priority
//   one arithmetic core serves every set, so only one request per cycle

module address_modifier_arithmetic #(
  parameter int NUM_SETS = addr_mod_pkg::NUM_SETS,
  parameter int SET_W = addr_mod_pkg::SET_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [SET_W-1:0] req_set,
  input wire addr_mod_pkg::upd_kind_e req_kind,
  input wire logic [23:0] pc_value,
  input wire logic [23:0] pc_disp,
  input wire logic wr_ptr_en,
  input wire logic wr_ofs_en,
  input wire logic wr_mod_en,
  input wire logic [SET_W-1:0] wr_set,
  input wire logic [23:0] wr_data,
  input wire logic [SET_W-1:0] rd_set,
  output logic [23:0] rd_ptr,
  output logic [23:0] rd_ofs,
  output logic [23:0] rd_mod,
  output logic ea_valid,
  output logic [23:0] ea_addr,
  output logic [23:0] ea_new_ptr,
  output addr_mod_pkg::arith_e ea_arith
);

  // ****************************************
  // helpers
  // ****************************************
  // one set-select compare shared by every load and update path
  function automatic logic set_hit(input logic [SET_W-1:0] sel, input int idx);
    return sel == SET_W'(idx);
  endfunction

  // modes whose operand address is the computed sum rather than the old pointer
  function automatic logic addr_from_sum(input addr_mod_pkg::upd_kind_e kind);
    logic hit;
    hit = 1'b0;
    case (kind)
      addr_mod_pkg::UPD_INDEXED, addr_mod_pkg::UPD_PRE_DEC,
      addr_mod_pkg::UPD_PC_REL: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ****************************************
  // register sets
  // ****************************************
  logic [23:0] address_pointer_reg_ff [NUM_SETS];
  logic [23:0] address_offset_reg_ff [NUM_SETS];
  logic [23:0] address_modifier_reg_ff [NUM_SETS];
  logic [23:0] nxt_address_pointer_reg [NUM_SETS];
  logic [23:0] nxt_address_offset_reg [NUM_SETS];
  logic [23:0] nxt_address_modifier_reg [NUM_SETS];

  logic ea_valid_ff;
  logic [23:0] ea_addr_ff;
  logic [23:0] ea_new_ptr_ff;
  addr_mod_pkg::arith_e ea_arith_ff;
  logic nxt_ea_valid;
  logic [23:0] nxt_ea_addr;
  logic [23:0] nxt_ea_new_ptr;
  addr_mod_pkg::arith_e nxt_ea_arith;

  // ****************************************
  // operand selection
  // ****************************************
  logic [23:0] cur_ptr;
  logic [23:0] cur_ofs;
  logic [23:0] cur_mod;
  logic [23:0] op_base;
  logic [23:0] op_val;
  logic op_sub;
  logic op_pc;
  logic [23:0] arith_res;
  addr_mod_pkg::arith_e arith_type;
  logic ptr_update;

  // the pointer's own modifier is always the one used; the lookup is a plain
  // mux of flip-flops, so a request sees the registers as of before its edge
  always_comb begin
    cur_ptr = address_pointer_reg_ff[req_set];
    cur_ofs = address_offset_reg_ff[req_set];
    cur_mod = address_modifier_reg_ff[req_set];
    op_base = cur_ptr;
    op_val = 24'h000000;
    op_sub = 1'b0;
    op_pc = 1'b0;
    ptr_update = 1'b0;
    case (req_kind)
      addr_mod_pkg::UPD_POST_INC: begin
        op_val = 24'h000001;
        ptr_update = 1'b1;
      end
      addr_mod_pkg::UPD_POST_DEC, addr_mod_pkg::UPD_PRE_DEC: begin
        op_val = 24'h000001;
        op_sub = 1'b1;
        ptr_update = 1'b1;
      end
      addr_mod_pkg::UPD_POST_ADD: begin
        op_val = cur_ofs;
        ptr_update = 1'b1;
      end
      addr_mod_pkg::UPD_POST_SUB: begin
        op_val = cur_ofs;
        op_sub = 1'b1;
        ptr_update = 1'b1;
      end
      addr_mod_pkg::UPD_INDEXED: begin
        op_val = cur_ofs;
      end
      addr_mod_pkg::UPD_PC_REL: begin
        op_base = pc_value;
        op_val = pc_disp;
        op_pc = 1'b1;
      end
      default: begin
        op_val = 24'h000000;
      end
    endcase
  end

  // one shared arithmetic core: only one request is taken per cycle, so a
  // core per set would cost area for nothing
  mod_arith_core #(
    .AW(addr_mod_pkg::ADDR_W)
  ) u_core (
    .base_addr(op_base),
    .operand(op_val),
    .subtract(op_sub),
    .modifier(cur_mod),
    .force_linear(op_pc),
    .result(arith_res),
    .arith(arith_type)
  );

  // ****************************************
  // result stage
  // ****************************************
  // post modes address with the old pointer; pre-decrement and indexed use the sum
  // ea_addr, ea_new_ptr and ea_arith hold between requests so a slow consumer may read them late
  always_comb begin
    nxt_ea_valid = req_valid;
    nxt_ea_arith = arith_type;
    nxt_ea_new_ptr = cur_ptr;
    nxt_ea_addr = cur_ptr;
    if (req_valid) begin
      if (addr_from_sum(req_kind)) begin
        nxt_ea_addr = arith_res;
      end
      if (ptr_update) begin
        nxt_ea_new_ptr = arith_res;
      end
    end else begin
      nxt_ea_addr = ea_addr_ff;
      nxt_ea_new_ptr = ea_new_ptr_ff;
      nxt_ea_arith = ea_arith_ff;
    end
  end

  // result registers only; every decision is taken in the block above
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_valid_ff <= 1'b0;
      ea_addr_ff <= 24'h000000;
      ea_new_ptr_ff <= 24'h000000;
      ea_arith_ff <= addr_mod_pkg::ARITH_LINEAR;
    end else begin
      ea_valid_ff <= nxt_ea_valid;
      ea_addr_ff <= nxt_ea_addr;
      ea_new_ptr_ff <= nxt_ea_new_ptr;
      ea_arith_ff <= nxt_ea_arith;
    end
  end

  // ****************************************
  // register write-back
  // ****************************************
  // direct loads win over an update of the same pointer in the same cycle, so a
  // reload issued alongside a post-update is never overwritten by the stale sum
  for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
    always_comb begin
      nxt_address_pointer_reg[g] = address_pointer_reg_ff[g];
      nxt_address_offset_reg[g] = address_offset_reg_ff[g];
      nxt_address_modifier_reg[g] = address_modifier_reg_ff[g];
      if (req_valid && ptr_update && set_hit(req_set, g)) begin
        nxt_address_pointer_reg[g] = arith_res;
      end
      if (wr_ptr_en && set_hit(wr_set, g)) begin
        nxt_address_pointer_reg[g] = wr_data;
      end
      if (wr_ofs_en && set_hit(wr_set, g)) begin
        nxt_address_offset_reg[g] = wr_data;
      end
      if (wr_mod_en && set_hit(wr_set, g)) begin
        nxt_address_modifier_reg[g] = wr_data;
      end
    end

    // set registers only; the offset word is never touched by an update
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        address_pointer_reg_ff[g] <= addr_mod_pkg::PTR_RST;
        address_offset_reg_ff[g] <= addr_mod_pkg::OFS_RST;
        address_modifier_reg_ff[g] <= addr_mod_pkg::MOD_RST;
      end else begin
        address_pointer_reg_ff[g] <= nxt_address_pointer_reg[g];
        address_offset_reg_ff[g] <= nxt_address_offset_reg[g];
        address_modifier_reg_ff[g] <= nxt_address_modifier_reg[g];
      end
    end
  end

  // readback of register sets is registered data; the pick itself is a plain mux
  assign rd_ptr = address_pointer_reg_ff[rd_set];
  assign rd_ofs = address_offset_reg_ff[rd_set];
  assign rd_mod = address_modifier_reg_ff[rd_set];
  assign ea_valid = ea_valid_ff;
  assign ea_addr = ea_addr_ff;
  assign ea_new_ptr = ea_new_ptr_ff;
  assign ea_arith = ea_arith_ff;

endmodule

// ---- test/addr_mod_arith_chk.sv ----
// Purpose: port-level checks for the address modifier arithmetic unit
// Assumes: the stimulus stub keeps rd_set equal to req_set
// Notes: results are tied to the register values seen at the request edge
module addr_mod_arith_chk #(
  parameter int NUM_SETS = 8,
  parameter int SET_W = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [SET_W-1:0] req_set,
  input wire addr_mod_pkg::upd_kind_e req_kind,
  input wire logic [23:0] pc_value,
  input wire logic [23:0] pc_disp,
  input wire logic wr_ptr_en,
  input wire logic [SET_W-1:0] rd_set,
  input wire logic [23:0] rd_ptr,
  input wire logic [23:0] rd_mod,
  input wire logic ea_valid,
  input wire logic [23:0] ea_addr,
  input wire logic [23:0] ea_new_ptr,
  input wire addr_mod_pkg::arith_e ea_arith
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sel;
  logic pow2;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // only a request on the watched set says anything about rd_ptr and rd_mod
  assign sel = req_valid && (rd_set == req_set);
  assign pow2 = ((rd_mod[13:0] & (rd_mod[13:0] + 14'h0001)) == 14'h0000) && |rd_mod[13:0];

  a_valid_follows_req: assert property (req_valid |=> ea_valid)
    else $error("result strobe missing after request");
  a_valid_needs_req: assert property (ea_valid |-> $past(req_valid))
    else $error("result strobe without request");
  a_ea_holds: assert property (!ea_valid |-> $stable(ea_addr))
    else $error("address moved without request");
  a_post_old_ptr: assert property (sel && req_kind inside {addr_mod_pkg::UPD_POST_INC,
    addr_mod_pkg::UPD_POST_ADD, addr_mod_pkg::UPD_POST_SUB} |=> ea_addr == $past(rd_ptr))
    else $error("post update did not use old pointer");
  a_linear_step: assert property (sel && req_kind == addr_mod_pkg::UPD_POST_INC &&
    rd_mod[15:0] == 16'hFFFF |=> ea_new_ptr == $past(rd_ptr) + 24'h000001)
    else $error("linear increment wrong");
  a_reverse_pick: assert property (sel && rd_mod[15:0] == 16'h0000 &&
    req_kind != addr_mod_pkg::UPD_PC_REL |=> ea_arith == addr_mod_pkg::ARITH_REVERSE)
    else $error("reverse carry not selected");
  a_mwrap_pick: assert property (sel && rd_mod[15:14] == 2'h2 && pow2 &&
    req_kind != addr_mod_pkg::UPD_PC_REL |=> ea_arith == addr_mod_pkg::ARITH_MWRAP)
    else $error("multiple wrap not selected");
  a_index_keeps: assert property (sel && req_kind == addr_mod_pkg::UPD_INDEXED |=>
    ea_new_ptr == $past(rd_ptr))
    else $error("indexed access changed pointer");
  a_pcrel_linear: assert property (req_valid && req_kind == addr_mod_pkg::UPD_PC_REL |=>
    ea_addr == $past(pc_value) + $past(pc_disp) && ea_arith == addr_mod_pkg::ARITH_LINEAR)
    else $error("pc relative address not linear");
  a_ptr_writeback: assert property (ea_valid && !$past(wr_ptr_en) &&
    rd_set == $past(req_set) |-> rd_ptr == ea_new_ptr)
    else $error("pointer not written back");

  c_reverse: cover property (ea_valid && ea_arith == addr_mod_pkg::ARITH_REVERSE);
  c_modulo: cover property (ea_valid && ea_arith == addr_mod_pkg::ARITH_MODULO);
  c_mwrap: cover property (ea_valid && ea_arith == addr_mod_pkg::ARITH_MWRAP);
endmodule

// ---- test/addr_gen_stub.sv ----
// Purpose: stand-in for the decode and address generation stages
// Assumes: inputs change 2 ns after a rising edge
// Notes: one idle cycle between operations keeps each strobe a clean pulse
module addr_gen_stub (
  input wire logic clk,
  output logic req_valid,
  output logic [2:0] req_set,
  output addr_mod_pkg::upd_kind_e req_kind,
  output logic [23:0] pc_value,
  output logic [23:0] pc_disp,
  output logic wr_ptr_en,
  output logic wr_ofs_en,
  output logic wr_mod_en,
  output logic [2:0] wr_set,
  output logic [23:0] wr_data,
  output logic [2:0] rd_set
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {req_valid, wr_ptr_en, wr_ofs_en, wr_mod_en} = 4'h0;
    {req_set, wr_set} = 6'h00;
    req_kind = addr_mod_pkg::UPD_NONE;
    {pc_value, pc_disp, wr_data} = 72'h0;
  end
  // read port follows the set in use so results can be checked against it
  assign rd_set = req_set;

  // ****************************************
  // register loads and requests
  // ****************************************
  // only listed modifiers and in-range offsets are ever loaded
  task automatic load(input logic [1:0] which, input logic [2:0] set, input logic [23:0] d);
    @(posedge clk);
    #2;
    wr_set = set;
    wr_data = d;
    wr_ptr_en = (which == 2'h0);
    wr_ofs_en = (which == 2'h1);
    wr_mod_en = (which == 2'h2);
    @(posedge clk);
    #2;
    {wr_ptr_en, wr_ofs_en, wr_mod_en} = 3'h0;
    wr_data = ~d; // released data must not look valid
  endtask

  task automatic issue(input logic [2:0] set, input addr_mod_pkg::upd_kind_e k,
    input logic [23:0] pc, input logic [23:0] dp);
    @(posedge clk);
    #2;
    req_set = set;
    req_kind = k;
    pc_value = pc;
    pc_disp = dp;
    req_valid = 1'b1;
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    pc_value = ~pc;
  endtask
endmodule

// ---- test/address_modifier_arithmetic_test.sv ----
// Purpose: directed scenarios for the linear, reverse, modulo and multiple-wrap modifier types of the address unit
// Assumes: one request in flight; result checked in the cycle it stands
// Notes: expected values are worked out here from the modifier rules
module address_modifier_arithmetic_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, wr_ptr_en, wr_ofs_en, wr_mod_en, ea_valid;
  logic [2:0] req_set, wr_set, rd_set, cs;
  addr_mod_pkg::upd_kind_e req_kind;
  addr_mod_pkg::arith_e ea_arith, car;
  logic [23:0] pc_value, pc_disp, wr_data, rd_ptr, rd_ofs, rd_mod, ea_addr, ea_new_ptr;
  int error_cnt = 0;
  int comparisons = 0;

  address_modifier_arithmetic i_dut (.clk, .rst_n, .req_valid, .req_set, .req_kind, .pc_value,
    .pc_disp, .wr_ptr_en, .wr_ofs_en, .wr_mod_en, .wr_set, .wr_data, .rd_set, .rd_ptr,
    .rd_ofs, .rd_mod, .ea_valid, .ea_addr, .ea_new_ptr, .ea_arith);
  addr_gen_stub i_stub (.clk, .req_valid, .req_set, .req_kind, .pc_value, .pc_disp,
    .wr_ptr_en, .wr_ofs_en, .wr_mod_en, .wr_set, .wr_data, .rd_set);

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic ld(input logic [1:0] which, input logic [23:0] d);
    i_stub.load(which, cs, d);
  endtask

  // one request on the current set, judged while its result stands
  task automatic run(input addr_mod_pkg::upd_kind_e k, input logic [23:0] ea,
    input logic [23:0] nw, input logic [23:0] pc = 24'h000000, input logic [23:0] dp = 24'h000000);
    i_stub.issue(cs, k, pc, dp);
    chk("ea_valid", 24'h000001, {23'h0, ea_valid});
    chk("ea_addr", ea, ea_addr);
    chk("ea_new_ptr", nw, ea_new_ptr);
    chk("rd_ptr", nw, rd_ptr);
    chk("ea_arith", {21'h0, car}, {21'h0, ea_arith});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_linear;
    cs = 3'h1;
    car = addr_mod_pkg::ARITH_LINEAR;
    chk("rd_mod", 24'hFFFFFF, rd_mod);
    ld(2'h2, 24'hAAFFFF);
    ld(2'h0, 24'hFFFFFF);
    run(addr_mod_pkg::UPD_POST_INC, 24'hFFFFFF, 24'h000000);
    ld(2'h1, 24'hFFFFFF);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000000, 24'hFFFFFF);
  endtask

  task automatic t_reverse;
    cs = 3'h2;
    car = addr_mod_pkg::ARITH_REVERSE;
    ld(2'h2, 24'h550000);
    ld(2'h0, 24'h000000);
    ld(2'h1, 24'h800000);
    // mirrored counting: the top bit takes the carry-in, carries ripple downwards
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000000, 24'h800000);
    chk("rd_ofs", 24'h800000, rd_ofs);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h800000, 24'h400000);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h400000, 24'hC00000);
    run(addr_mod_pkg::UPD_POST_SUB, 24'hC00000, 24'h400000);
  endtask

  task automatic t_modulo;
    cs = 3'h3;
    car = addr_mod_pkg::ARITH_MODULO;
    ld(2'h2, 24'h000004);
    ld(2'h0, 24'h000104);
    ld(2'h1, 24'h000008);
    run(addr_mod_pkg::UPD_POST_INC, 24'h000104, 24'h000100);
    run(addr_mod_pkg::UPD_POST_DEC, 24'h000100, 24'h000104);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000104, 24'h00010C);
    run(addr_mod_pkg::UPD_POST_SUB, 24'h00010C, 24'h000104);
    run(addr_mod_pkg::UPD_PRE_DEC, 24'h000103, 24'h000103);
    ld(2'h1, 24'h000003);
    run(addr_mod_pkg::UPD_INDEXED, 24'h000101, 24'h000103);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000103, 24'h000101);
    car = addr_mod_pkg::ARITH_LINEAR;
    run(addr_mod_pkg::UPD_PC_REL, 24'h000010, 24'h000101, 24'hFFFFF0, 24'h000020);
    // a negative offset of magnitude below M must wrap through the bottom as well
    car = addr_mod_pkg::ARITH_MODULO;
    ld(2'h1, 24'hFFFFFE);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000101, 24'h000104);
  endtask

  task automatic t_mwrap;
    cs = 3'h4;
    car = addr_mod_pkg::ARITH_MWRAP;
    ld(2'h2, 24'h008007);
    ld(2'h0, 24'h000205);
    ld(2'h1, 24'h000013);
    run(addr_mod_pkg::UPD_POST_ADD, 24'h000205, 24'h000200);
    run(addr_mod_pkg::UPD_POST_SUB, 24'h000200, 24'h000205);
    run(addr_mod_pkg::UPD_INDEXED, 24'h000200, 24'h000205);
    ld(2'h0, 24'h000200);
    run(addr_mod_pkg::UPD_POST_DEC, 24'h000200, 24'h000207);
    run(addr_mod_pkg::UPD_POST_INC, 24'h000207, 24'h000200);
  endtask

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 400 cycles
  initial begin
    #(2000 * 25);
    error_cnt++;
    results();
  end

  initial begin
    cs = 3'h0;
    car = addr_mod_pkg::ARITH_LINEAR;
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    chk("rd_ptr", 24'h000000, rd_ptr);
    t_linear();
    t_reverse();
    t_modulo();
    t_mwrap();
    results();
  end
endmodule

bind address_modifier_arithmetic addr_mod_arith_chk #(.NUM_SETS(NUM_SETS), .SET_W(SET_W)) i_chk (
  .clk, .rst_n, .req_valid, .req_set, .req_kind, .pc_value, .pc_disp, .wr_ptr_en, .rd_set,
  .rd_ptr, .rd_mod, .ea_valid, .ea_addr, .ea_new_ptr, .ea_arith);
